// ===== design/reset_sequencer_clock_guard.sv
// reset sequencer with clock security system and avalon status registers
//
// Notes on behaviour
// - three reset sources: pin, low voltage, watchdog
// - every source drives reset pin low
// - vector fetched from fffe then ffff
// - phases: source delay, 4096 cycles, fetch
// - vector fetch lasts two cycles
// - pin low caught without the clock
// - external reset drives pin minimum width
// - watchdog underflow drives pin minimum width
// - pin held low while low voltage
// - low voltage flag set, cleared writing zero
// - threshold level fixed by option
// - oscillator keeps running during reset
// - seven clock source types by option
// - clock security enabled only by option
// - filter suppresses high frequency spikes
// - filtering continues after source recovers, while security is enabled
// - missing clock switches to backup oscillator
// - recovered clock switches back automatically
// - fault flag set, read clears, option forces
// - fault interrupt when flag and enable
// - watchdog flag cleared by zero or lvd
// - halt disables security, freezes fault flag and interrupt enable
//
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module reset_sequencer_clock_guard #(
   parameter int EXT_PULSE_NS = 1000,
   parameter int WDG_PULSE_NS = 1000,
   parameter int LVD_DELAY_NS = 1000,
   parameter int FILT_MIN_CYC = 2,
   parameter int BACKUP_PERIOD_CYC = 64
) (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_reset_pin_in,
   output logic o_reset_pin_out,
   output logic o_reset_pin_oe_n,
   input wire logic i_lvd_reset,
   input wire logic i_wdg_underflow,
   input wire logic i_halt,
   input wire logic i_main_clk,
   input wire logic [1:0] i_opt_lvd_level,
   input wire clock_reset_pkg::clk_type_type i_opt_clk_type,
   input wire logic i_opt_css_enable,
   output logic [1:0] o_lvd_level,
   output clock_reset_pkg::clk_type_type o_clk_type,
   output logic o_osc_enable,
   output logic o_sys_clk,
   output logic o_safe_clock_sel,
   output logic o_core_reset,
   output logic o_vector_fetch,
   output logic [15:0] o_vector_addr,
   output logic o_clock_fault_irq,
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest
);
   import clock_reset_pkg::*;

   localparam int EXT_CYC_I = (EXT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WDG_CYC_I = (WDG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LVD_CYC_I = (LVD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [CNT_W-1:0] EXT_LAST = CNT_W'((EXT_CYC_I < 1) ? 0 : EXT_CYC_I - 1);
   localparam logic [CNT_W-1:0] WDG_LAST = CNT_W'((WDG_CYC_I < 1) ? 0 : WDG_CYC_I - 1);
   localparam logic [CNT_W-1:0] LVD_LAST = CNT_W'((LVD_CYC_I < 1) ? 0 : LVD_CYC_I - 1);
   localparam logic [CNT_W-1:0] FILT_LAST = CNT_W'(FILT_MIN_CYC - 1);
   localparam logic [CNT_W-1:0] MISS_LAST = CNT_W'(BACKUP_PERIOD_CYC - 1);
   localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(BACKUP_PERIOD_CYC / 2 - 1);

   seq_state_type state_ff, nxt_state;
   reset_src_type src_ff, nxt_src;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt, drive_last;
   logic ext_latch_ff, ext_sync1_ff, ext_sync2_ff, latch_clear;
   logic pin_oe_n_ff, core_reset_ff, fetch_ff;
   logic [15:0] vec_ff;
   logic opt_load_ff, css_en_ff;
   logic [1:0] lvl_ff;
   clk_type_type clk_type_ff;
   logic osc_en_ff;
   logic main_q_ff, filt_ff, filt_d_ff, filt_rise;
   logic [CNT_W-1:0] filt_cnt_ff, miss_cnt_ff, bk_cnt_ff;
   logic bk_lvl_ff, safe_sel_ff, sys_clk_ff;
   logic lvd_flag_ff, wdg_flag_ff, irq_en_ff, safe_flag_ff, irq_ff;
   logic wait_ff, wr_status, rd_status;
   logic [31:0] rdata_ff, status_word, option_word;
   logic [CNT_W-1:0] low_cnt_ff;

   // external pin caught asynchronously, then synchronised
   always_ff @(posedge i_mclk or negedge i_reset_pin_in) begin
      if (!i_reset_pin_in) begin
         ext_latch_ff <= 1'b1;
      end else if (i_reset || latch_clear) begin
         ext_latch_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk) begin
      ext_sync1_ff <= ext_latch_ff;
      ext_sync2_ff <= ext_sync1_ff;
   end

   assign latch_clear = (state_ff == ST_DRIVE) || (state_ff == ST_HOLD);

   always_comb begin
      case (src_ff)
         SRC_LVD: drive_last = LVD_LAST;
         SRC_WDG: drive_last = WDG_LAST;
         default: drive_last = EXT_LAST;
      endcase
   end

   // sequencer next state
   always_comb begin
      nxt_state = state_ff;
      nxt_src = src_ff;
      nxt_cnt = cnt_ff;
      if (i_lvd_reset) begin
         nxt_state = ST_DRIVE;
         nxt_src = SRC_LVD;
         nxt_cnt = '0;
      end else if (i_wdg_underflow) begin
         nxt_state = ST_DRIVE;
         nxt_src = SRC_WDG;
         nxt_cnt = '0;
      end else if (ext_sync2_ff && !latch_clear) begin
         nxt_state = ST_DRIVE;
         nxt_src = SRC_EXT;
         nxt_cnt = '0;
      end else begin
         case (state_ff)
            ST_DRIVE: begin
               if (cnt_ff >= drive_last) begin
                  nxt_state = ST_HOLD;
                  nxt_cnt = '0;
               end else begin
                  nxt_cnt = cnt_ff + 1'b1;
               end
            end
            ST_HOLD: begin
               if (ext_sync2_ff) begin
                  nxt_cnt = '0;
               end else if (cnt_ff == HOLD_SETTLE) begin
                  nxt_state = ST_STAB;
                  nxt_cnt = '0;
               end else begin
                  nxt_cnt = cnt_ff + 1'b1;
               end
            end
            ST_STAB: begin
               if (cnt_ff == STAB_CYCLES - 1'b1) begin
                  nxt_state = ST_FETCH;
                  nxt_cnt = '0;
               end else begin
                  nxt_cnt = cnt_ff + 1'b1;
               end
            end
            ST_FETCH: begin
               if (cnt_ff == FETCH_CYCLES - 1'b1) begin
                  nxt_state = ST_RUN;
                  nxt_cnt = '0;
               end else begin
                  nxt_cnt = cnt_ff + 1'b1;
               end
            end
            default: begin
               nxt_state = ST_RUN;
               nxt_cnt = '0;
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         state_ff <= ST_HOLD;
         src_ff <= SRC_EXT;
         cnt_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         src_ff <= nxt_src;
         cnt_ff <= nxt_cnt;
      end
   end

   // sequencer outputs, all released on a clock edge
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         pin_oe_n_ff <= 1'b1;
         core_reset_ff <= 1'b1;
         fetch_ff <= 1'b0;
         vec_ff <= 16'h0000;
      end else begin
         pin_oe_n_ff <= (nxt_state != ST_DRIVE);
         core_reset_ff <= (nxt_state != ST_RUN) && (nxt_state != ST_FETCH);
         fetch_ff <= (nxt_state == ST_FETCH);
         if (nxt_state == ST_FETCH) begin
            vec_ff <= nxt_cnt[0] ? VECTOR_HI : VECTOR_LO;
         end else begin
            vec_ff <= 16'h0000;
         end
      end
   end

   // option straps caught once after reset release
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         opt_load_ff <= 1'b1;
         lvl_ff <= 2'h0;
         clk_type_ff <= CLK_EXTERNAL;
         css_en_ff <= 1'b0;
      end else if (opt_load_ff) begin
         opt_load_ff <= 1'b0;
         lvl_ff <= i_opt_lvd_level;
         clk_type_ff <= i_opt_clk_type;
         css_en_ff <= i_opt_css_enable;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         osc_en_ff <= 1'b1;
      end else begin
         osc_en_ff <= !i_halt || (nxt_state != ST_RUN);
      end
   end

   // spike filter on the sampled main clock
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         main_q_ff <= 1'b0;
         filt_ff <= 1'b0;
         filt_d_ff <= 1'b0;
         filt_cnt_ff <= '0;
      end else begin
         main_q_ff <= i_main_clk;
         filt_d_ff <= filt_ff;
         if (main_q_ff == filt_ff) begin
            filt_cnt_ff <= '0;
         end else if (filt_cnt_ff >= FILT_LAST) begin
            filt_ff <= main_q_ff;
            filt_cnt_ff <= '0;
         end else begin
            filt_cnt_ff <= filt_cnt_ff + 1'b1;
         end
      end
   end

   assign filt_rise = filt_ff && !filt_d_ff;

   // missing clock watch and backup selection
   always_ff @(posedge i_mclk) begin
      if (i_reset || !css_en_ff) begin
         miss_cnt_ff <= '0;
         safe_sel_ff <= 1'b0;
      end else if (!i_halt) begin
         if (filt_rise) begin
            miss_cnt_ff <= '0;
            safe_sel_ff <= 1'b0;
         end else if (miss_cnt_ff == MISS_LAST) begin
            safe_sel_ff <= 1'b1;
         end else begin
            miss_cnt_ff <= miss_cnt_ff + 1'b1;
         end
      end
   end

   // backup oscillator, stopped in halt
   always_ff @(posedge i_mclk) begin
      if (i_reset || !css_en_ff || i_halt) begin
         bk_cnt_ff <= '0;
         bk_lvl_ff <= 1'b0;
      end else if (bk_cnt_ff == HALF_LAST) begin
         bk_cnt_ff <= '0;
         bk_lvl_ff <= !bk_lvl_ff;
      end else begin
         bk_cnt_ff <= bk_cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset || i_halt) begin
         sys_clk_ff <= 1'b0;
      end else if (!css_en_ff) begin
         sys_clk_ff <= main_q_ff;
      end else if (safe_sel_ff) begin
         sys_clk_ff <= bk_lvl_ff;
      end else begin
         sys_clk_ff <= filt_ff;
      end
   end

   // avalon slave, one wait cycle per access
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         wait_ff <= 1'b1;
      end else if ((i_avs_read || i_avs_write) && wait_ff) begin
         wait_ff <= 1'b0;
      end else begin
         wait_ff <= 1'b1;
      end
   end

   assign wr_status = i_avs_write && !wait_ff && i_avs_byteenable[0]
      && (i_avs_address == ADDR_STATUS);
   assign rd_status = i_avs_read && !wait_ff && (i_avs_address == ADDR_STATUS);

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[BIT_LVD_FLAG] = lvd_flag_ff;
      status_word[BIT_IRQ_EN] = irq_en_ff;
      status_word[BIT_SAFE_FLAG] = safe_flag_ff;
      status_word[BIT_WDG_FLAG] = wdg_flag_ff;
      option_word = 32'h0000_0000;
      option_word[OPT_LVL_LSB +: 2] = lvl_ff;
      option_word[OPT_CLK_LSB +: 3] = clk_type_ff;
      option_word[OPT_CSS_BIT] = css_en_ff;
      option_word[OPT_SAFE_BIT] = safe_sel_ff;
      option_word[OPT_RST_BIT] = core_reset_ff;
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         rdata_ff <= 32'h0000_0000;
      end else if (i_avs_read && wait_ff) begin
         if (i_avs_address == ADDR_STATUS) begin
            rdata_ff <= status_word;
         end else if (i_avs_address == ADDR_OPTION) begin
            rdata_ff <= option_word;
         end else begin
            rdata_ff <= 32'h0000_0000;
         end
      end
   end

   // reset cause flags
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         lvd_flag_ff <= STATUS_RESET;
      end else if (i_lvd_reset) begin
         lvd_flag_ff <= 1'b1;
      end else if (wr_status && !i_avs_writedata[BIT_LVD_FLAG]) begin
         lvd_flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         wdg_flag_ff <= STATUS_RESET;
      end else if (i_lvd_reset) begin
         wdg_flag_ff <= 1'b0;
      end else if (i_wdg_underflow) begin
         wdg_flag_ff <= 1'b1;
      end else if (wr_status && !i_avs_writedata[BIT_WDG_FLAG]) begin
         wdg_flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         irq_en_ff <= STATUS_RESET;
      end else if (wr_status && !i_halt) begin
         irq_en_ff <= i_avs_writedata[BIT_IRQ_EN];
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset || !css_en_ff) begin
         safe_flag_ff <= 1'b0;
      end else if (!i_halt) begin
         if (safe_sel_ff) begin
            safe_flag_ff <= 1'b1;
         end else if (rd_status) begin
            safe_flag_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= safe_flag_ff && irq_en_ff && css_en_ff;
      end
   end

   assign o_reset_pin_out = 1'b0;
   assign o_reset_pin_oe_n = pin_oe_n_ff;
   assign o_lvd_level = lvl_ff;
   assign o_clk_type = clk_type_ff;
   assign o_osc_enable = osc_en_ff;
   assign o_sys_clk = sys_clk_ff;
   assign o_safe_clock_sel = safe_sel_ff;
   assign o_core_reset = core_reset_ff;
   assign o_vector_fetch = fetch_ff;
   assign o_vector_addr = vec_ff;
   assign o_clock_fault_irq = irq_ff;
   assign o_avs_readdata = rdata_ff;
   assign o_avs_waitrequest = wait_ff;

   // cycles the reset pin has been driven low so far
   always_ff @(posedge i_mclk) begin
      if (i_reset || pin_oe_n_ff) begin
         low_cnt_ff <= '0;
      end else if (low_cnt_ff != '1) begin
         low_cnt_ff <= low_cnt_ff + 1'b1;
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_reset);

   a_pin_in_delay: assert property (
      (state_ff == ST_DRIVE) |-> !o_reset_pin_oe_n)
      else $error("reset pin not driven in delay phase");
   a_lvd_holds_pin: assert property (
      i_lvd_reset |=> (state_ff == ST_DRIVE) && !o_reset_pin_oe_n)
      else $error("low voltage did not hold reset pin");
   a_stab_count: assert property (
      $rose(state_ff == ST_FETCH) |-> $past(cnt_ff) == STAB_CYCLES - 1'b1
      && $past(state_ff) == ST_STAB)
      else $error("fetch entered without full stabilisation count");
   a_fetch_two: assert property (
      ($rose(o_vector_fetch) && !i_lvd_reset && !i_wdg_underflow && !ext_sync2_ff)
      |=> o_vector_fetch ##1 !o_vector_fetch)
      else $error("vector fetch not two cycles");
   a_vector_pair: assert property (
      $rose(o_vector_fetch) |-> o_vector_addr == VECTOR_LO)
      else $error("vector fetch not starting at low vector");
   a_drive_width: assert property (
      $rose(o_reset_pin_oe_n) |-> low_cnt_ff > drive_last)
      else $error("reset pin released too early");
   a_wdg_flag_set: assert property (
      (i_wdg_underflow && !i_lvd_reset) |=> wdg_flag_ff)
      else $error("watchdog flag not set");
   a_lvd_flag_set: assert property (
      i_lvd_reset |=> lvd_flag_ff && !wdg_flag_ff)
      else $error("low voltage flag not set");
   a_safe_after_miss: assert property (
      (css_en_ff && !i_halt && !filt_rise && miss_cnt_ff == MISS_LAST) |=> safe_sel_ff)
      else $error("backup clock not selected");
   a_irq_cause: assert property (
      o_clock_fault_irq |-> $past(safe_flag_ff) && $past(irq_en_ff))
      else $error("fault interrupt without flag and enable");
   a_css_off_flag: assert property (
      !css_en_ff |=> !safe_flag_ff && !safe_sel_ff)
      else $error("fault flag not forced low");
   c_fetch_done: cover property ($fell(o_vector_fetch));
   c_safe_clock: cover property ($rose(safe_sel_ff));
   c_recover: cover property ($fell(safe_sel_ff));
   c_ext_reset: cover property (ext_sync2_ff && state_ff == ST_RUN);
endmodule

// ===== design/clock_reset_pkg.sv
// constants and types shared by the reset sequencer and clock guard
package clock_reset_pkg;
   localparam int CLK_PERIOD_NS = 40;
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] STAB_CYCLES = 16'h1000;
   localparam logic [CNT_W-1:0] FETCH_CYCLES = 16'h0002;
   localparam logic [CNT_W-1:0] HOLD_SETTLE = 16'h0003;
   localparam logic [15:0] VECTOR_LO = 16'hfffe;
   localparam logic [15:0] VECTOR_HI = 16'hffff;
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_OPTION = 4'h4;
   localparam int BIT_WDG_FLAG = 0;
   localparam int BIT_SAFE_FLAG = 1;
   localparam int BIT_IRQ_EN = 2;
   localparam int BIT_LVD_FLAG = 4;
   localparam int OPT_LVL_LSB = 0;
   localparam int OPT_CLK_LSB = 2;
   localparam int OPT_CSS_BIT = 5;
   localparam int OPT_SAFE_BIT = 6;
   localparam int OPT_RST_BIT = 7;
   localparam logic STATUS_RESET = 1'b0;
   typedef enum logic [4:0] {
      ST_RUN = 5'b00001,
      ST_DRIVE = 5'b00010,
      ST_HOLD = 5'b00100,
      ST_STAB = 5'b01000,
      ST_FETCH = 5'b10000
   } seq_state_type;
   typedef enum logic [1:0] {
      SRC_EXT = 2'h0,
      SRC_LVD = 2'h1,
      SRC_WDG = 2'h2
   } reset_src_type;
   typedef enum logic [2:0] {
      CLK_EXTERNAL = 3'h0,
      CLK_RESON_0 = 3'h1,
      CLK_RESON_1 = 3'h2,
      CLK_RESON_2 = 3'h3,
      CLK_RESON_3 = 3'h4,
      CLK_EXT_RC = 3'h5,
      CLK_INT_RC = 3'h6
   } clk_type_type;
endpackage

// ===== verification/reset_board_model.sv
// board model: open-drain reset wire with pull-up, reset switch, main oscillator
`timescale 1ns/1ps
module reset_board_model (
   input wire logic i_mclk,
   input wire logic i_pin_out,
   input wire logic i_pin_oe_n,
   input wire logic i_pull_low,
   input wire logic i_osc_run,
   input wire logic i_spike,
   input wire logic [3:0] i_half,
   output logic o_pin,
   output logic o_main_clk
);
   logic [3:0] cnt_ff = 4'h0;
   logic osc_ff = 1'b0;
   // any party pulls low, the pull-up wins otherwise
   assign o_pin = (i_pull_low || (!i_pin_oe_n && !i_pin_out)) ? 1'b0 : 1'b1;
   // oscillator free-runs whatever the reset state; stopped it shows only spikes
   always @(posedge i_mclk) begin
      if (cnt_ff >= i_half - 4'h1) begin
         cnt_ff <= 4'h0;
         osc_ff <= ~osc_ff;
      end else begin
         cnt_ff <= cnt_ff + 4'h1;
      end
   end
   assign o_main_clk = i_osc_run ? osc_ff : i_spike;
endmodule

// ===== verification/tb_reset_sequencer_clock_guard.sv
// self-checking bench for the reset sequencer and clock guard
`timescale 1ns/1ps
module tb_reset_sequencer_clock_guard;
   import clock_reset_pkg::*;
   localparam int DLY_NS = 200;
   localparam int DLY_CYC = DLY_NS / CLK_PERIOD_NS;
   localparam int BK_CYC = 8;
   logic clk, rst, pin, pull, low_voltage_detector, wdg, halt, main_clk, run, spike, clock_security_system;
   logic rd, wr;
   logic [3:0] half, addr, be;
   logic [1:0] lvl;
   clk_type_type ctype;
   logic [31:0] wdata, rdata, seed;
   logic pin_out, oe_n, osc_en, sys_clk, safe, core_rst, fetch, irq, waitreq;
   logic [1:0] lvl_o;
   clk_type_type ctype_o;
   logic [15:0] vaddr;
   logic [31:0] rdat_o;
   int failures = 0;
   int checks_done = 0;
   int p;
   logic sc;

   reset_sequencer_clock_guard #(.EXT_PULSE_NS(DLY_NS), .WDG_PULSE_NS(DLY_NS),
      .LVD_DELAY_NS(DLY_NS), .FILT_MIN_CYC(2), .BACKUP_PERIOD_CYC(BK_CYC)) uut (
      .i_mclk(clk), .i_reset(rst), .i_reset_pin_in(pin), .o_reset_pin_out(pin_out),
      .o_reset_pin_oe_n(oe_n), .i_lvd_reset(low_voltage_detector), .i_wdg_underflow(wdg), .i_halt(halt),
      .i_main_clk(main_clk), .i_opt_lvd_level(lvl), .i_opt_clk_type(ctype),
      .i_opt_css_enable(clock_security_system), .o_lvd_level(lvl_o), .o_clk_type(ctype_o),
      .o_osc_enable(osc_en), .o_sys_clk(sys_clk), .o_safe_clock_sel(safe),
      .o_core_reset(core_rst), .o_vector_fetch(fetch), .o_vector_addr(vaddr),
      .o_clock_fault_irq(irq), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdat_o),
      .o_avs_waitrequest(waitreq));

   reset_board_model board (.i_mclk(clk), .i_pin_out(pin_out), .i_pin_oe_n(oe_n),
      .i_pull_low(pull), .i_osc_run(run), .i_spike(spike), .i_half(half), .o_pin(pin),
      .o_main_clk(main_clk));

   initial begin
      clk = 1'b0;
      forever #(CLK_PERIOD_NS / 2) clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [31:0] stat_exp(input logic l, e, s, w);
      logic [31:0] v;
      v = 32'h0;
      v[BIT_LVD_FLAG] = l;
      v[BIT_IRQ_EN] = e;
      v[BIT_SAFE_FLAG] = s;
      v[BIT_WDG_FLAG] = w;
      return v;
   endfunction

   function automatic logic [31:0] opt_exp(input logic [1:0] l, input logic [2:0] t,
      input logic c);
      return {24'h0, 2'h0, c, t, l};
   endfunction

   task automatic complete_run();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      while (waitreq !== 1'b0) @(posedge clk);
      d = rdat_o;
      rd <= 1'b0;
   endtask

   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      while (waitreq !== 1'b0) @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      bus_rd(a, rdata);
      chk(rdata, exp);
   endtask

   task automatic wait_fetch(output int n);
      n = 0;
      while (fetch !== 1'b1 && n < 6000) begin
         @(negedge clk);
         n++;
      end
      chk(vaddr, VECTOR_LO);
      @(negedge clk);
      chk({fetch, vaddr}, {1'b1, VECTOR_HI});
      @(negedge clk);
      chk({fetch, core_rst}, 2'b00);
   endtask

   task automatic seq_check(input int min_low);
      int c;
      int n;
      c = 0;
      while (oe_n === 1'b0 && c < 300) begin
         @(negedge clk);
         c++;
      end
      chk(c >= min_low, 1'b1);
      wait_fetch(n);
      chk(n >= int'(STAB_CYCLES) && n <= int'(STAB_CYCLES + HOLD_SETTLE) + 8, 1'b1);
   endtask

   task automatic restart(input logic c);
      int n;
      clock_security_system <= c;
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk({osc_en, core_rst}, 2'b11);
      wait_fetch(n);
   endtask

   initial begin
      #(CLK_PERIOD_NS * 40000);
      failures++;
      complete_run();
   end

   initial begin
      seed = 32'h2182;
      {rst, pull, low_voltage_detector, wdg, halt, spike, rd, wr} = 8'h80;
      run = 1'b1;
      addr = 4'h0;
      wdata = 32'h0;
      be = 4'hf;
      half = 4'h2 + 4'(rnd() % 2);
      lvl = 2'(rnd() % 3);
      ctype = clk_type_type'(3'(rnd() % 7));
      clock_security_system = 1'b1;
      restart(1'b1);
      rd_chk(ADDR_OPTION, opt_exp(lvl, ctype, 1'b1));
      chk({lvl_o, ctype_o}, {lvl, ctype});
      rd_chk(ADDR_STATUS, 32'h0);
      rd_chk(4'h8, 32'h0);
      $display("test startup done");
      @(posedge clk);
      wdg <= 1'b1;
      @(posedge clk);
      wdg <= 1'b0;
      @(negedge clk);
      chk({pin_out, oe_n, pin, core_rst, osc_en}, 5'h03);
      seq_check(DLY_CYC);
      rd_chk(ADDR_STATUS, stat_exp(1'b0, 1'b0, 1'b0, 1'b1));
      $display("test watchdog done");
      p = 3 + int'(rnd() % 6);
      @(posedge clk);
      low_voltage_detector <= 1'b1;
      @(negedge clk);
      repeat (p) begin
         @(negedge clk);
         chk({oe_n, pin}, 2'b00);
      end
      @(posedge clk);
      low_voltage_detector <= 1'b0;
      @(negedge clk);
      seq_check(DLY_CYC);
      rd_chk(ADDR_STATUS, stat_exp(1'b1, 1'b0, 1'b0, 1'b0));
      $display("test low voltage done");
      p = 4 + int'(rnd() % 4);
      @(posedge clk);
      pull <= 1'b1;
      repeat (4) @(negedge clk);
      chk(oe_n, 1'b0);
      repeat (p - 4) @(negedge clk);
      @(posedge clk);
      pull <= 1'b0;
      @(negedge clk);
      seq_check(DLY_CYC + 3 - p);
      rd_chk(ADDR_STATUS, stat_exp(1'b1, 1'b0, 1'b0, 1'b0));
      be <= 4'he;
      bus_wr(ADDR_STATUS, 32'h0);
      rd_chk(ADDR_STATUS, stat_exp(1'b1, 1'b0, 1'b0, 1'b0));
      be <= 4'hf;
      bus_wr(ADDR_STATUS, 32'h0);
      rd_chk(ADDR_STATUS, 32'h0);
      $display("test external pin done");
      bus_wr(ADDR_STATUS, stat_exp(1'b0, 1'b1, 1'b0, 1'b0));
      @(posedge clk);
      run <= 1'b0;
      for (int k = 0; k < 40; k++) begin
         @(posedge clk);
         spike <= (k % 3 == 1);
      end
      @(negedge clk);
      chk({safe, irq}, 2'b11);
      sc = sys_clk;
      p = 0;
      repeat (2 * BK_CYC) begin
         @(negedge clk);
         p += int'(sys_clk && !sc);
         sc = sys_clk;
      end
      chk(p, 2);
      rd_chk(ADDR_STATUS, stat_exp(1'b0, 1'b1, 1'b1, 1'b0));
      @(posedge clk);
      run <= 1'b1;
      spike <= 1'b0;
      p = 0;
      while (safe !== 1'b0 && p < 40) begin
         @(negedge clk);
         p++;
      end
      chk(safe, 1'b0);
      rd_chk(ADDR_STATUS, stat_exp(1'b0, 1'b1, 1'b1, 1'b0));
      rd_chk(ADDR_STATUS, stat_exp(1'b0, 1'b1, 1'b0, 1'b0));
      chk(irq, 1'b0);
      $display("test clock guard done");
      @(posedge clk);
      halt <= 1'b1;
      run <= 1'b0;
      repeat (20) @(negedge clk);
      chk({osc_en, sys_clk, safe}, 3'b000);
      bus_wr(ADDR_STATUS, 32'h0);
      rd_chk(ADDR_STATUS, stat_exp(1'b0, 1'b1, 1'b0, 1'b0));
      @(posedge clk);
      halt <= 1'b0;
      run <= 1'b1;
      $display("test halt done");
      restart(1'b0);
      @(posedge clk);
      run <= 1'b0;
      repeat (30) @(negedge clk);
      chk({safe, irq, sys_clk}, 3'b000);
      rd_chk(ADDR_STATUS, 32'h0);
      $display("test guard disabled done");
      complete_run();
   end
endmodule
